// ---- core/tism_pkg.sv ----
// Package for the timer interrupt status and mask block.
// Assumes a 32-bit register port with byte offsets as printed.

package tism_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_SRC = 7;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [11:0] OFS_INTERRUPT_ENABLE_MASK    = 12'h018;
  localparam logic [11:0] OFS_RAW_INTERRUPT_STATUS     = 12'h01C;
  localparam logic [11:0] OFS_MASKED_INTERRUPT_STATUS  = 12'h020;
  localparam logic [11:0] OFS_INTERRUPT_CLEAR          = 12'h024;

  // ****************************************
  // Bit positions of the sources
  // ****************************************
  localparam int unsigned BIT_FIRST_TIMEOUT  = 0;
  localparam int unsigned BIT_CAP1_MATCH     = 1;
  localparam int unsigned BIT_CAP1_EDGE      = 2;
  localparam int unsigned BIT_CLOCK_EVENT    = 3;
  localparam int unsigned BIT_SECOND_TIMEOUT = 8;
  localparam int unsigned BIT_CAP2_MATCH     = 9;
  localparam int unsigned BIT_CAP2_EDGE      = 10;
  localparam int unsigned FIELD_W            = 11;

  // Bits 10:8 and 3:0 implemented, 7:4 read zero
  localparam logic [10:0] IMPL_MASK   = 11'h70F;
  localparam logic [10:0] FIELD_RESET = 11'h000;
  localparam logic [31:0] DATA_RESET  = 32'h0000_0000;

endpackage : tism_pkg

// ---- core/tism_core.sv ----
// Interrupt mask, raw status and masked status of a general timer module.
// Assumes event inputs are one-cycle or level pulses synchronous to ref_clk_in.
//
// Notes on behaviour
// - Mask bit one enables, zero disables
// - Mask bits 10,9,8: cap2 edge, match, timeout
// - Mask bits 3..0: clock, cap1 edge, match, timeout
// - Raw bit sets on event, mask ignored
// - Raw bit clears only by clear write one or by reset
// - Masked bit equals raw and mask
// - Clear write one also clears masked bit
// - Raw register same positions, read only
// - Masked register same positions, writes ignored
// - Bits 7:4 zero; upper bits read zero
// - Clear at 0x024 clears ones only
//
// Implementation choice: the plain strobed port.

`timescale 1ns/100ps
`default_nettype none

module tism_core
  import tism_pkg::*;
(
  input  wire logic                ref_clk_in,
  input  wire logic                nrst_in,
  input  wire logic [ADDR_W-1:0]   addr_in,
  input  wire logic [DATA_W-1:0]   wdata_in,
  input  wire logic                wr_in,
  input  wire logic                rd_in,
  input  wire logic                first_timeout_evt_in,
  input  wire logic                cap1_match_evt_in,
  input  wire logic                cap1_edge_evt_in,
  input  wire logic                clock_event_evt_in,
  input  wire logic                second_timeout_evt_in,
  input  wire logic                cap2_match_evt_in,
  input  wire logic                cap2_edge_evt_in,
  output logic [DATA_W-1:0]        rdata_out,
  output logic                     irq_out
);

  // ****************************************
  // Event collection
  // ****************************************
  logic [FIELD_W-1:0] evt_vec;
  logic [FIELD_W-1:0] mask_reg;
  logic [FIELD_W-1:0] raw_reg;
  logic [FIELD_W-1:0] raw_next;
  logic [FIELD_W-1:0] masked;
  logic [FIELD_W-1:0] clr_vec;
  logic               wr_mask;
  logic               wr_clear;

  always_comb begin
    evt_vec                     = '0;
    evt_vec[BIT_FIRST_TIMEOUT]  = first_timeout_evt_in;
    evt_vec[BIT_CAP1_MATCH]     = cap1_match_evt_in;
    evt_vec[BIT_CAP1_EDGE]      = cap1_edge_evt_in;
    evt_vec[BIT_CLOCK_EVENT]    = clock_event_evt_in;
    evt_vec[BIT_SECOND_TIMEOUT] = second_timeout_evt_in;
    evt_vec[BIT_CAP2_MATCH]     = cap2_match_evt_in;
    evt_vec[BIT_CAP2_EDGE]      = cap2_edge_evt_in;
  end

  assign wr_mask  = wr_in && (addr_in == OFS_INTERRUPT_ENABLE_MASK);
  assign wr_clear = wr_in && (addr_in == OFS_INTERRUPT_CLEAR);
  assign clr_vec  = wr_clear ? (wdata_in[FIELD_W-1:0] & IMPL_MASK) : '0;

  // ****************************************
  // Mask register
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mask_reg <= FIELD_RESET;
    end else if (wr_mask) begin
      // Upper bits dropped, 7:4 held zero
      mask_reg <= wdata_in[FIELD_W-1:0] & IMPL_MASK;
    end
  end

  // ****************************************
  // Raw status, per bit
  // ****************************************
  // Set wins over a clear in the same cycle, so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < FIELD_W; gi++) begin : g_raw
      always_comb begin
        if (IMPL_MASK[gi] && evt_vec[gi]) begin
          raw_next[gi] = 1'b1;
        end else if (clr_vec[gi]) begin
          raw_next[gi] = 1'b0;
        end else begin
          raw_next[gi] = raw_reg[gi] & IMPL_MASK[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      raw_reg <= FIELD_RESET;
    end else begin
      raw_reg <= raw_next;
    end
  end

  // Masked view follows raw, so a clear drops both together
  assign masked = raw_reg & mask_reg;

  // ****************************************
  // Read port and interrupt line
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= DATA_RESET;
    end else if (rd_in) begin
      unique case (addr_in)
        OFS_INTERRUPT_ENABLE_MASK:   rdata_out <= {21'h000000, mask_reg};
        OFS_RAW_INTERRUPT_STATUS:    rdata_out <= {21'h000000, raw_reg};
        OFS_MASKED_INTERRUPT_STATUS: rdata_out <= {21'h000000, masked};
        default:                     rdata_out <= DATA_RESET;
      endcase
    end else begin
      rdata_out <= DATA_RESET;
    end
  end

  // Registered from next values so irq tracks status with no extra lag
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(raw_next & (wr_mask ? (wdata_in[FIELD_W-1:0] & IMPL_MASK) : mask_reg));
    end
  end

endmodule : tism_core

`default_nettype wire

// ---- tb/tism_assertions.sv ----
// Checker on the tism_core ports; bound at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module tism_chk import tism_pkg::*; (
  input wire logic        ref_clk_in, nrst_in, wr_in, rd_in, first_timeout_evt_in, irq_out,
  input wire logic [11:0] addr_in,
  input wire logic [31:0] wdata_in, rdata_out);
  logic m0_reg;
  wire  m_wr = wr_in && addr_in == 12'h018;
  always_ff @(posedge ref_clk_in or negedge nrst_in) if (!nrst_in) m0_reg <= 1'b0;
    else if (m_wr) m0_reg <= wdata_in[0];
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0) else $error("stray data");
  rsvd_zero_a: assert property ($past(rd_in) |-> {rdata_out[31:11], rdata_out[7:4]} == 25'h0) else $error("rsvd");
  mask_read_a: assert property (rd_in && addr_in == 12'h018 |=> rdata_out[0] == m0_reg) else $error("mask");
  evt_irq_a: assert property (first_timeout_evt_in && m0_reg && !m_wr |=> irq_out) else $error("no irq");
  irq_fall_a: assert property ($fell(irq_out) |-> $past(wr_in)) else $error("irq fell");
  ro_write_a: assert property (wr_in && addr_in inside {12'h01C, 12'h020} && irq_out |=> irq_out) else $error("ro");
  mask_off_a: assert property (m_wr && wdata_in[10:0] == 11'h0 |=> !irq_out) else $error("off");
  rst_clear_a: assert property (disable iff (1'b0) !nrst_in |-> !irq_out && rdata_out == 32'h0) else $error("rst");
  cover property ($rose(irq_out));
  cover property ($fell(irq_out));
  cover property (m_wr);
endmodule // tism_chk
bind tism_core tism_chk chk_u (.*);
`default_nettype wire

// ---- tb/tism_evt_src.sv ----
// Stand-in for the timer event logic; bench sets pulses.
`timescale 1ns/100ps
`default_nettype none
module tism_evt_src (input wire logic [6:0] fire_in, output logic [6:0] ev_out);
  assign ev_out = fire_in; // One-cycle pulses
endmodule // tism_evt_src
`default_nettype wire

// ---- tb/tb_tism_core.sv ----
// Bench: register tasks and event pulses against tism_core.
`timescale 1ns/100ps
`default_nettype none
module tb_tism_core import tism_pkg::*;;
  logic        ref_clk_in = 1'b0, nrst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, irq_out;
  logic [11:0] addr_in = 12'h000;
  logic [31:0] wdata_in = 32'h0, rdata_out, b, e = 32'h70F;
  logic [6:0]  f = 7'h00, ev;
  int          n_errors = 0, cmp_count = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  tism_evt_src src_u (.fire_in(f), .ev_out(ev));
  tism_core dut_u (.*, .first_timeout_evt_in(ev[0]), .cap1_match_evt_in(ev[1]), .cap1_edge_evt_in(ev[2]),
    .clock_event_evt_in(ev[3]), .second_timeout_evt_in(ev[4]), .cap2_match_evt_in(ev[5]), .cap2_edge_evt_in(ev[6]));
  task automatic ck(input logic [31:0] g, x);
    cmp_count++;
    if (g !== x) begin n_errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, x); end
  endtask
  // Write when w is high, else read and compare with d
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    addr_in <= a; wdata_in <= d; wr_in <= w; rd_in <= !w;
    @(posedge ref_clk_in) {wr_in, rd_in} <= 2'b00;
    #1 if (!w) ck(rdata_out, d);
  endtask
  task automatic fire(input logic [6:0] v);
    f <= v;
    @(posedge ref_clk_in) f <= 7'h00;
    #1;
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin #20000 n_errors++; conclude(); end
  initial begin
    // Falling edge at time zero so the asynchronous reset really fires
    nrst_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    #1 for (int i = 0; i < 5; i++) bus(0, 12'h014 + 12'(4 * i), 32'h0);
    bus(1, 12'h018, 32'h7FF);
    bus(0, 12'h018, 32'h70F);
    bus(1, 12'h018, 32'h0);
    fire(7'h7F);
    bus(0, 12'h01C, 32'h70F);
    bus(0, 12'h020, 32'h0);
    for (int i = 0; i < 11; i++) if (e[i]) begin
      b = 32'h1 << i;
      bus(1, 12'h018, b);
      bus(0, 12'h020, b);
      ck({31'h0, irq_out}, 32'h1);
      bus(1, 12'h024, b);
      e = e & ~b;
      bus(0, 12'h01C, e);
      ck({31'h0, irq_out}, 32'h0);
    end
    bus(1, 12'h018, 32'h1);
    fire(7'h01);
    bus(1, 12'h01C, 32'h70F);
    bus(1, 12'h020, 32'h70F);
    bus(0, 12'h01C, 32'h1);
    ck({31'h0, irq_out}, 32'h1);
    // Reset in mid-run with a pending interrupt
    nrst_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    #1 ck({31'h0, irq_out}, 32'h0);
    bus(0, 12'h018, 32'h0);
    bus(0, 12'h01C, 32'h0);
    conclude();
  end
endmodule // tb_tism_core
`default_nettype wire
